// *** design/pbat_bridge.sv ***
// peripheral access bridge: decodes ranges and holds the master for the access latency
`timescale 1ns/1ps
`default_nettype none
`include "pbat_defs.svh"
// Operation
// - latency counted in the range's reference clock
// - latency is bus, sync and wait summed
// - equal clocks give a fixed sync count
// - faster core adds at least one period
// - writes unbuffered; master stalls until done
// - contention from other masters lengthens accesses
// - converter range: five/four, or two-five/two-four
// - fractional bounds: minimum truncated, maximum rounded up
// - serial halfword registers take two more cycles
// - word data register access takes two more
module pbat_bridge import pbat_pkg::*; (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] FAST_DIV,
  input wire logic [3:0] SLOW_DIV,
  input wire logic BUS_CONTEND,
  input wire logic REQ_VALID,
  input wire pbat_req_t REQ,
  output logic REQ_READY,
  output logic RESP_VALID,
  output pbat_resp_t RESP,
  output logic PER_STB,
  output pbat_req_t PER_ACC,
  input wire logic [31:0] PER_RDATA
);
  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_COUNT, ST_RESP} pbat_state_t;

  logic [1:0] rst_pipe_r;
  logic rst_n;
  logic [3:0] div_pin [2];
  logic [3:0] div_meta_r [2];
  logic [3:0] div_sync_r [2];
  logic [3:0] ph_r [2];
  logic [1:0] tick;
  logic [1:0] div_eq;
  pbat_state_t st_r;
  pbat_prof_t prof;
  pbat_ref_t ref_r;
  logic [3:0] cnt_r;
  logic [31:0] rdata_r;
  logic err_r;
  logic acc;
  logic eq_now;
  logic tick_sel;
  logic step;

  // ****************************************************************
  // reset release
  // ****************************************************************
  // async assert, release through two flops so every register leaves reset together
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  // ****************************************************************
  // divided peripheral clocks as enables on the core clock
  // ****************************************************************
  assign div_pin[0] = FAST_DIV;
  assign div_pin[1] = SLOW_DIV;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div
      // ratio straps come from pins; two flops before use
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          div_meta_r[g] <= 4'h1;
          div_sync_r[g] <= 4'h1;
        end else begin
          div_meta_r[g] <= div_pin[g];
          div_sync_r[g] <= div_meta_r[g];
        end
      end
      // phase counter; a ratio of zero is treated as one
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          ph_r[g] <= 4'h0;
        end else if (ph_r[g] + 4'h1 >= div_sync_r[g]) begin
          ph_r[g] <= 4'h0;
        end else begin
          ph_r[g] <= ph_r[g] + 4'h1;
        end
      end
      assign tick[g] = (ph_r[g] == 4'h0);
      assign div_eq[g] = (div_sync_r[g] <= 4'h1);
    end
  endgenerate

  // ****************************************************************
  // decode and handshake
  // ****************************************************************
  pbat_profile u_profile (
    .req(REQ),
    .prof(prof)
  );

  // held low until the internal reset copy lets go, so no request is lost in reset
  assign REQ_READY = (st_r == ST_IDLE) && rst_n;
  assign acc = REQ_VALID && REQ_READY;
  assign eq_now = (prof.refc == PBAT_REF_FAST) ? div_eq[0] : div_eq[1];

  // count edges of the range's own reference clock
  always_comb begin
    unique case (ref_r)
      PBAT_REF_FAST: tick_sel = tick[0];
      PBAT_REF_SLOW: tick_sel = tick[1];
      default: tick_sel = 1'b1;
    endcase
  end
  // another master on the bus freezes the count
  assign step = tick_sel && !BUS_CONTEND;
  // the peripheral is touched on the last counted cycle only
  assign PER_STB = (st_r == ST_COUNT) && step && (cnt_r == 4'h1);
  assign RESP_VALID = (st_r == ST_RESP);
  assign RESP = '{rdata: rdata_r, err: err_r};

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (acc && !prof.hit) begin
            st_r <= ST_RESP; // unmapped: answered at once, no peripheral touched
          end else if (acc && prof.refc != PBAT_REF_CORE && !eq_now) begin
            st_r <= ST_ALIGN;
          end else if (acc) begin
            st_r <= ST_COUNT;
          end
        end
        ST_ALIGN: begin
          if (step) begin
            st_r <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (PER_STB) begin
            st_r <= ST_RESP;
          end
        end
        ST_RESP: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // latency load: the table figure already holds bus, sync and wait parts
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (acc && prof.refc != PBAT_REF_CORE && !eq_now) begin
      // alignment edge is one period, so count one fewer after it
      cnt_r <= prof.uneq_cnt - 4'h1;
    end else if (acc) begin
      cnt_r <= prof.eq_cnt; // fixed with equal clocks
    end else if (st_r == ST_COUNT && step) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // request captured so the peripheral side sees stable flops
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PER_ACC <= '0;
      ref_r <= PBAT_REF_CORE;
    end else if (acc) begin
      PER_ACC <= REQ;
      ref_r <= prof.refc;
    end
  end

  // read data and error held until the next request is accepted
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (acc) begin
      err_r <= !prof.hit;
      rdata_r <= 32'h0000_0000;
    end else if (PER_STB && !PER_ACC.write) begin
      rdata_r <= PER_RDATA;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  conv_read_eq_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && REQ.addr == `PBAT_CONV_LO && !REQ.write && div_eq[0])
    ##1 (!BUS_CONTEND && div_eq[0])[*5] |-> PER_STB)
    else $error("converter read latency wrong");
  conv_write_eq_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && REQ.addr == `PBAT_CONV_LO && REQ.write && div_eq[0])
    ##1 (!BUS_CONTEND && div_eq[0])[*4] |-> PER_STB)
    else $error("converter write latency wrong");
  core_count_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && REQ.addr == `PBAT_CTRL_LO && !REQ.write)
    ##1 (!BUS_CONTEND)[*2] |-> PER_STB)
    else $error("core range latency wrong");
  slow_fixed_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && REQ.addr == `PBAT_MSTOP_LO && !REQ.write && div_eq[1])
    ##1 (!BUS_CONTEND && div_eq[1])[*5] |-> PER_STB && !$past(PER_STB))
    else $error("equal clock latency not fixed");
  sercom_extra_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && REQ.addr == `PBAT_SERCOM_LO && REQ.write &&
     REQ.size == `PBAT_SIZE_HALF && div_eq[0])
    ##1 (!BUS_CONTEND && div_eq[0])[*6] |-> PER_STB)
    else $error("serial halfword latency wrong");
  spi_extra_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && REQ.addr == (`PBAT_SPI_LO | {20'h0_0000, `PBAT_SPI_DATA_OFS}) &&
     !REQ.write && REQ.size == `PBAT_SIZE_WORD && div_eq[0])
    ##1 (!BUS_CONTEND && div_eq[0])[*7] |-> PER_STB)
    else $error("word data register latency wrong");
  contend_stall_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (st_r == ST_COUNT && BUS_CONTEND) |-> !PER_STB ##1 (st_r != ST_IDLE))
    else $error("access finished under contention");
  sync_align_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && prof.hit && prof.refc != PBAT_REF_CORE && !eq_now) |=> (st_r == ST_ALIGN))
    else $error("no synchronisation period added");
  answer_after_a: assert property (@(posedge CLK) disable iff (!rst_n)
    PER_STB |=> RESP_VALID && !REQ_READY && (PER_ACC.write || RESP.rdata == $past(PER_RDATA)))
    else $error("answer not after peripheral access");
  unmapped_err_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (acc && !prof.hit) |=> RESP_VALID && RESP.err ##1 REQ_READY)
    else $error("unmapped access not answered with error");

  conv_read_c: cover property (@(posedge CLK) disable iff (!rst_n)
    acc && REQ.addr == `PBAT_CONV_LO && !REQ.write);
  uneq_access_c: cover property (@(posedge CLK) disable iff (!rst_n)
    st_r == ST_ALIGN ##[1:40] PER_STB);
  contend_c: cover property (@(posedge CLK) disable iff (!rst_n)
    st_r == ST_COUNT && BUS_CONTEND);
  unmapped_c: cover property (@(posedge CLK) disable iff (!rst_n)
    RESP_VALID && RESP.err);
endmodule : pbat_bridge
`default_nettype wire

// *** design/pbat_defs.svh ***
// address ranges, latency profiles and encodings of the peripheral access bridge
`ifndef PBAT_DEFS_SVH
`define PBAT_DEFS_SVH

// ****************************************************************
// access size codes
// ****************************************************************
`define PBAT_SIZE_BYTE 2'h0
`define PBAT_SIZE_HALF 2'h1
`define PBAT_SIZE_WORD 2'h2

// ****************************************************************
// latency packing: rd_eq,wr_eq,rd_lo,rd_hi,wr_lo,wr_hi (4 bits each)
// ****************************************************************
`define PBAT_NUM_ROWS 20
`define PBAT_ROW_SERCOM 15
`define PBAT_ROW_SPI 16
`define PBAT_EXTRA 4'h2
`define PBAT_SPI_DATA_OFS 12'h004

`define PBAT_CTRL_LO 32'h4000_0000
`define PBAT_CTRL_HI 32'h4000_6fff
`define PBAT_CTRL_CNT 24'h222222
`define PBAT_SECDBG_LO 32'h4000_8000
`define PBAT_SECDBG_HI 32'h4001_cfff
`define PBAT_SECDBG_CNT 24'h434433
`define PBAT_SYSA_LO 32'h4001_e000
`define PBAT_SYSA_HI 32'h4001_e3ff
`define PBAT_SYSA_CNT 24'h545544
`define PBAT_SYSB_LO 32'h4001_e400
`define PBAT_SYSB_HI 32'h4001_e5ff
`define PBAT_SYSB_CNT 24'h985858
`define PBAT_PORT_LO 32'h4008_0000
`define PBAT_PORT_HI 32'h4008_0fff
`define PBAT_PORT_CNT 24'h542524
`define PBAT_EVT_LO 32'h4008_2000
`define PBAT_EVT_HI 32'h4008_3fff
`define PBAT_EVT_CNT 24'h543524
`define PBAT_MSTOP_LO 32'h4008_4000
`define PBAT_MSTOP_HI 32'h4008_4fff
`define PBAT_MSTOP_CNT 24'h542524
`define PBAT_POE_LO 32'h4008_a000
`define PBAT_POE_HI 32'h4008_afff
`define PBAT_POE_CNT 24'h543524
`define PBAT_USBA_LO 32'h4009_0000
`define PBAT_USBA_HI 32'h4009_03ff
`define PBAT_USBA_CNT 24'h653635
`define PBAT_USBB_LO 32'h4009_0400
`define PBAT_USBB_HI 32'h4009_04ff
`define PBAT_USBB_CNT 24'h431413
`define PBAT_IIC_LO 32'h4009_2000
`define PBAT_IIC_HI 32'h4009_ffff
`define PBAT_IIC_CNT 24'h542524
`define PBAT_CANU_LO 32'h400a_8000
`define PBAT_CANU_HI 32'h400a_9fff
`define PBAT_CANU_CNT 24'h542524
`define PBAT_PSEC_LO 32'h400e_0000
`define PBAT_PSEC_HI 32'h400e_0fff
`define PBAT_PSEC_CNT 24'h542524
`define PBAT_LPTMR_LO 32'h400e_8000
`define PBAT_LPTMR_HI 32'h400e_8fff
`define PBAT_LPTMR_CNT 24'h745724
`define PBAT_CALC_LO 32'h4010_8000
`define PBAT_CALC_HI 32'h4010_9fff
`define PBAT_CALC_CNT 24'h542524
`define PBAT_SERCOM_LO 32'h4011_8000
`define PBAT_SERCOM_HI 32'h4011_8fff
`define PBAT_SERCOM_CNT 24'h542524
`define PBAT_SPI_LO 32'h4011_a000
`define PBAT_SPI_HI 32'h4011_afff
`define PBAT_SPI_CNT 24'h542524
`define PBAT_CRYPT_LO 32'h4016_1000
`define PBAT_CRYPT_HI 32'h4016_1fff
`define PBAT_CRYPT_CNT 24'h643624
`define PBAT_PWM_LO 32'h4016_9000
`define PBAT_PWM_HI 32'h4016_9fff
`define PBAT_PWM_CNT 24'h744724
`define PBAT_CONV_LO 32'h4017_0000
`define PBAT_CONV_HI 32'h4017_2fff
`define PBAT_CONV_CNT 24'h542524

`endif

// *** design/pbat_pkg.sv ***
// types shared by the peripheral access bridge
package pbat_pkg;
  // reference clock of a decoded range
  typedef enum logic [1:0] {PBAT_REF_CORE, PBAT_REF_FAST, PBAT_REF_SLOW} pbat_ref_t;
  // master request carried with its address and data
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [31:0] wdata;
  } pbat_req_t;
  // answer to the master
  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } pbat_resp_t;
  // one row of the range table
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [23:0] cnt;
    pbat_ref_t refc;
  } pbat_row_t;
  // decoded latency profile
  typedef struct packed {
    logic hit;
    pbat_ref_t refc;
    logic [3:0] eq_cnt;
    logic [3:0] uneq_cnt;
  } pbat_prof_t;
endpackage : pbat_pkg

// *** design/pbat_profile.sv ***
// address decoder that picks the latency profile of a peripheral range
`timescale 1ns/1ps
`default_nettype none
`include "pbat_defs.svh"
module pbat_profile import pbat_pkg::*; (
  input wire pbat_req_t req,
  output pbat_prof_t prof
);
  // ****************************************************************
  // range table
  // ****************************************************************
  localparam int NROW = `PBAT_NUM_ROWS;
  localparam pbat_row_t ROWS [NROW] = '{
    '{`PBAT_CTRL_LO, `PBAT_CTRL_HI, `PBAT_CTRL_CNT, PBAT_REF_CORE},
    '{`PBAT_SECDBG_LO, `PBAT_SECDBG_HI, `PBAT_SECDBG_CNT, PBAT_REF_CORE},
    '{`PBAT_SYSA_LO, `PBAT_SYSA_HI, `PBAT_SYSA_CNT, PBAT_REF_CORE},
    '{`PBAT_SYSB_LO, `PBAT_SYSB_HI, `PBAT_SYSB_CNT, PBAT_REF_SLOW},
    '{`PBAT_PORT_LO, `PBAT_PORT_HI, `PBAT_PORT_CNT, PBAT_REF_SLOW},
    '{`PBAT_EVT_LO, `PBAT_EVT_HI, `PBAT_EVT_CNT, PBAT_REF_SLOW},
    '{`PBAT_MSTOP_LO, `PBAT_MSTOP_HI, `PBAT_MSTOP_CNT, PBAT_REF_SLOW},
    '{`PBAT_POE_LO, `PBAT_POE_HI, `PBAT_POE_CNT, PBAT_REF_SLOW},
    '{`PBAT_USBA_LO, `PBAT_USBA_HI, `PBAT_USBA_CNT, PBAT_REF_SLOW},
    '{`PBAT_USBB_LO, `PBAT_USBB_HI, `PBAT_USBB_CNT, PBAT_REF_SLOW},
    '{`PBAT_IIC_LO, `PBAT_IIC_HI, `PBAT_IIC_CNT, PBAT_REF_SLOW},
    '{`PBAT_CANU_LO, `PBAT_CANU_HI, `PBAT_CANU_CNT, PBAT_REF_SLOW},
    '{`PBAT_PSEC_LO, `PBAT_PSEC_HI, `PBAT_PSEC_CNT, PBAT_REF_SLOW},
    '{`PBAT_LPTMR_LO, `PBAT_LPTMR_HI, `PBAT_LPTMR_CNT, PBAT_REF_SLOW},
    '{`PBAT_CALC_LO, `PBAT_CALC_HI, `PBAT_CALC_CNT, PBAT_REF_FAST},
    '{`PBAT_SERCOM_LO, `PBAT_SERCOM_HI, `PBAT_SERCOM_CNT, PBAT_REF_FAST},
    '{`PBAT_SPI_LO, `PBAT_SPI_HI, `PBAT_SPI_CNT, PBAT_REF_FAST},
    '{`PBAT_CRYPT_LO, `PBAT_CRYPT_HI, `PBAT_CRYPT_CNT, PBAT_REF_FAST},
    '{`PBAT_PWM_LO, `PBAT_PWM_HI, `PBAT_PWM_CNT, PBAT_REF_FAST},
    '{`PBAT_CONV_LO, `PBAT_CONV_HI, `PBAT_CONV_CNT, PBAT_REF_FAST}
  };

  logic [NROW-1:0] hit;
  logic extra;

  // one comparator pair per range
  genvar i;
  generate
    for (i = 0; i < NROW; i++) begin : g_row
      assign hit[i] = (req.addr >= ROWS[i].lo) && (req.addr <= ROWS[i].hi);
    end
  endgenerate

  // ****************************************************************
  // profile select; ranges never overlap so order does not matter
  // ****************************************************************
  always_comb begin
    prof = '0;
    for (int k = 0; k < NROW; k++) begin
      if (hit[k]) begin
        prof.hit = 1'b1;
        prof.refc = ROWS[k].refc;
        prof.eq_cnt = req.write ? ROWS[k].cnt[19:16] : ROWS[k].cnt[23:20];
        // upper bound of the unequal range, already rounded up
        prof.uneq_cnt = req.write ? ROWS[k].cnt[3:0] : ROWS[k].cnt[11:8];
      end
    end
    // halfword serial registers and the word data register cost two more
    extra = (hit[`PBAT_ROW_SERCOM] && (req.size == `PBAT_SIZE_HALF)) ||
            (hit[`PBAT_ROW_SPI] && (req.size == `PBAT_SIZE_WORD) &&
             (req.addr[11:0] == `PBAT_SPI_DATA_OFS));
    if (extra) begin
      prof.eq_cnt = prof.eq_cnt + `PBAT_EXTRA;
      prof.uneq_cnt = prof.uneq_cnt + `PBAT_EXTRA;
    end
  end
endmodule : pbat_profile
`default_nettype wire

// *** tb/pbat_periph_model.sv ***
// behavioural model of the peripheral register blocks behind the bridge
`timescale 1ns/1ps
`default_nettype none
module pbat_periph_model import pbat_pkg::*; (
  input wire logic clk,
  input wire pbat_req_t per_acc,
  input wire logic per_stb,
  output logic [31:0] per_rdata
);
  logic [31:0] mem_r [0:15];
  logic [31:0] last_r;
  // preset words so a read before any write is still predictable
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_r[i] = 32'h5a5a_0000 + 32'(i);
    end
    last_r = 32'h0;
  end
  // data valid in the strobe cycle only; a changing pattern elsewhere
  // so a bridge sampling at the wrong cycle never sees a lucky match
  always_comb begin
    if (per_stb) begin
      per_rdata = mem_r[per_acc.addr[5:2]];
    end else begin
      per_rdata = ~last_r;
    end
  end
  // write lands at the strobe edge, the pattern flips every cycle
  always @(posedge clk) begin
    if (per_stb && per_acc.write) begin
      mem_r[per_acc.addr[5:2]] <= per_acc.wdata;
    end
    last_r <= per_rdata;
  end
endmodule : pbat_periph_model
`default_nettype wire

// *** tb/peripheral_bus_access_timing_test.sv ***
// self-checking bench of the peripheral access bridge
`timescale 1ns/1ps
`default_nettype none
module peripheral_bus_access_timing_test import pbat_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] fast_div = 4'h1;
  logic [3:0] slow_div = 4'h1;
  logic contend = 1'b0;
  logic req_valid = 1'b0;
  pbat_req_t req = '0;
  logic req_ready, resp_valid, per_stb;
  pbat_resp_t resp;
  pbat_req_t per_acc;
  logic [31:0] per_rdata;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int lat;
  pbat_resp_t rsp;

  pbat_bridge DUT (.CLK(clk), .NRST(nrst), .FAST_DIV(fast_div), .SLOW_DIV(slow_div),
    .BUS_CONTEND(contend), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .RESP_VALID(resp_valid), .RESP(resp), .PER_STB(per_stb), .PER_ACC(per_acc),
    .PER_RDATA(per_rdata));
  pbat_periph_model periph (.clk(clk), .per_acc(per_acc), .per_stb(per_stb),
    .per_rdata(per_rdata));

  // 100 ns period
  always #50 clk = ~clk;

  // ****************************************************************
  // checks and closing
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic wrap_up();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // cut a hang short; all tests need well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ****************************************************************
  // one access: returns cycles from accept to strobe, and the answer
  // ****************************************************************
  task automatic access(input logic [31:0] a, input logic w, input logic [1:0] sz,
    input logic [31:0] wd, input int c_len, output int stb_n, output pbat_resp_t r);
    int n;
    int g;
    int busy_rdy;
    pbat_req_t exp_acc;
    n = 1;
    g = 0;
    busy_rdy = 0;
    stb_n = -1;
    exp_acc = '{addr: a, write: w, size: sz, wdata: wd};
    while (req_ready !== 1'b1 && g < 50) begin
      @(negedge clk);
      g++;
    end
    req = exp_acc;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    // other master holds the bus for c_len cycles from the second cycle
    while (resp_valid !== 1'b1 && n < 60) begin
      contend = (n >= 2 && n < 2 + c_len);
      #1;
      if (per_stb === 1'b1) begin
        stb_n = n;
        chk(32'(per_acc.addr), a);
        chk(per_acc.wdata, wd);
      end
      if (req_ready === 1'b1) busy_rdy++;
      @(negedge clk);
      n++;
    end
    contend = 1'b0;
    r = resp;
    chk(32'(resp_valid), 32'h1);
    chk(32'(busy_rdy), 32'h0);
    if (stb_n > 0) chk(32'(n - stb_n), 32'h1);
    @(negedge clk);
    chk(32'(resp_valid), 32'h0);
  endtask : access

  task automatic set_div(input logic [3:0] f, input logic [3:0] s);
    fast_div = f;
    slow_div = s;
    repeat (4) @(negedge clk);
  endtask : set_div

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_table();
    logic [31:0] ad [8] = '{32'h4000_0000, 32'h4000_8000, 32'h4001_e400, 32'h4009_0400,
      32'h400e_8000, 32'h4016_9000, 32'h4017_2ffc, 32'h4008_4000};
    int rd [8] = '{2, 4, 9, 4, 7, 7, 5, 5};
    int wr [8] = '{2, 3, 8, 3, 4, 4, 4, 4};
    for (int i = 0; i < 8; i++) begin
      access(ad[i], 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
      chk(32'(lat), 32'(rd[i]));
      access(ad[i], 1'b1, `PBAT_SIZE_WORD, 32'h1234_0000 + 32'(i), 0, lat, rsp);
      chk(32'(lat), 32'(wr[i]));
    end
    $display("test table done");
  endtask : t_table

  task automatic t_repeat();
    int first;
    access(32'h4017_0000, 1'b1, `PBAT_SIZE_WORD, 32'hc0de_0042, 0, lat, rsp);
    access(32'h4017_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, first, rsp);
    chk(rsp.rdata, 32'hc0de_0042);
    chk(32'(rsp.err), 32'h0);
    access(32'h4017_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'(first));
    $display("test repeat done");
  endtask : t_repeat

  task automatic t_sizes();
    access(32'h4011_8004, 1'b0, `PBAT_SIZE_HALF, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h7);
    access(32'h4011_8000, 1'b1, `PBAT_SIZE_HALF, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h6);
    access(32'h4011_8004, 1'b0, `PBAT_SIZE_BYTE, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h5);
    access(32'h4011_a004, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h7);
    access(32'h4011_a004, 1'b1, `PBAT_SIZE_HALF, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h4);
    access(32'h4011_a000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h5);
    $display("test sizes done");
  endtask : t_sizes

  task automatic t_contend();
    access(32'h4017_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 3, lat, rsp);
    chk(32'(lat), 32'h8);
    $display("test contention done");
  endtask : t_contend

  task automatic t_unmapped();
    // deliberate reserved-area access; the bridge answers with an error
    access(32'h4000_7000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'hffff_ffff);
    chk(32'(rsp.err), 32'h1);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_unequal();
    set_div(4'h2, 4'h3);
    access(32'h4017_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk_rng(lat, 9, 10);
    access(32'h4017_0000, 1'b1, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk_rng(lat, 7, 8);
    access(32'h4008_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk_rng(lat, 13, 15);
    access(32'h4000_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h2);
    set_div(4'h0, 4'h0);
    access(32'h4017_0000, 1'b0, `PBAT_SIZE_WORD, 32'h0, 0, lat, rsp);
    chk(32'(lat), 32'h5);
    $display("test unequal clocks done");
  endtask : t_unequal

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_table();
    t_repeat();
    t_sizes();
    t_contend();
    t_unmapped();
    t_unequal();
    wrap_up();
  end
endmodule : peripheral_bus_access_timing_test
`default_nettype wire
